/* rtl/pisel_pkg.sv */
// Constants for the port interrupt source selection block
package pisel_pkg;
	// Register bus address width and register offsets
	localparam int PISEL_AW = 24;
	localparam logic [23:0] PISEL_ADDR_AUX = 24'hFFE10C;
	localparam logic [23:0] PISEL_ADDR_PSEL = 24'hFFE10E;
	localparam logic [23:0] PISEL_ADDR_EDGE = 24'hFFE10F;
	localparam logic [23:0] PISEL_ADDR_PCSEL = 24'hFFE12E;
	localparam logic [23:0] PISEL_ADDR_ISTAT = 24'hFFE130;
	localparam logic [23:0] PISEL_ADDR_IMASK = 24'hFFE131;
	// Field positions
	localparam int PISEL_CMP_BIT = 7;
	localparam int PISEL_DBG_BIT = 0;
	// Writable masks and reset values
	localparam logic [7:0] PISEL_AUX_WMASK = 8'h81;
	localparam logic [7:0] PISEL_PC_WMASK = 8'h0F;
	localparam logic [7:0] PISEL_RST_VAL = 8'h00;
	// Status layout: bits 7:0 port A/D lines, bits 11:8 port C lines
	localparam int PISEL_NEV = 12;
	localparam logic [11:0] PISEL_EV_RST = 12'h000;
endpackage : pisel_pkg

/* rtl/pisel_top.sv */
// Port interrupt source selection in front of the interrupt controller
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module pisel_top
	import pisel_pkg::*;
#(
	parameter int NPORT = 8,
	parameter int NPC = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [23:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] port_a_pins,
	input wire logic [7:0] port_d_pins,
	input wire logic [3:0] port_c_pins,
	input wire logic comparator_out,
	input wire logic debug_unit_irq,
	input wire logic [3:0] dma_irq,
	output logic [7:0] ad_irq_req,
	output logic [3:0] pc_irq_req,
	output logic irq
);
	////////////////////////////////////////////////////////////////////
	// Elaboration checks: the register layout is fixed at 8 and 4 lines
	if (NPORT != 8 || NPC != 4) begin : g_bad_size
		$error("pisel_top serves only eight A/D and four C lines");
	end

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] aux_irq_source_select_q; // Comparator and debug routing
	logic [7:0] port_ad_irq_select_q; // A or D per line
	logic [7:0] port_irq_edge_select_q; // Edge polarity per line
	logic [7:0] portc_dma_irq_select_q; // DMA or port C per line
	logic [11:0] istat_q; // Sticky event status
	logic [11:0] imask_q; // Event enables
	logic [11:0] ev; // Events this cycle

	// Decoded write strobes
	logic wr_aux, wr_psel, wr_edge, wr_pc, wr_stat, wr_mask;
	assign wr_aux = reg_wr && reg_addr == PISEL_ADDR_AUX;
	assign wr_psel = reg_wr && reg_addr == PISEL_ADDR_PSEL;
	assign wr_edge = reg_wr && reg_addr == PISEL_ADDR_EDGE;
	assign wr_pc = reg_wr && reg_addr == PISEL_ADDR_PCSEL;
	assign wr_stat = reg_wr && (reg_addr == PISEL_ADDR_ISTAT
		|| reg_addr == PISEL_ADDR_ISTAT + 24'h000002);
	assign wr_mask = reg_wr && (reg_addr == PISEL_ADDR_IMASK
		|| reg_addr == PISEL_ADDR_IMASK + 24'h000002);

	// Configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aux_irq_source_select_q <= PISEL_RST_VAL;
			port_ad_irq_select_q <= PISEL_RST_VAL;
			port_irq_edge_select_q <= PISEL_RST_VAL;
			portc_dma_irq_select_q <= PISEL_RST_VAL;
		end else if (clk_en) begin
			// reserved aux bits: held zero whatever is written
			if (wr_aux) begin
				aux_irq_source_select_q <= reg_wdata & PISEL_AUX_WMASK;
			end
			if (wr_psel) begin
				port_ad_irq_select_q <= reg_wdata;
			end
			if (wr_edge) begin
				port_irq_edge_select_q <= reg_wdata;
			end
			// read-only upper: bits 7:4 never store
			if (wr_pc) begin
				portc_dma_irq_select_q <= reg_wdata & PISEL_PC_WMASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge history
	logic [7:0] a_s1_q, a_s2_q, d_s1_q, d_s2_q;
	logic [3:0] c_s1_q, c_s2_q, c_s3_q;
	logic [7:0] sel_q; // Previous selected level, per A/D line
	logic [1:0] cmp_s_q, dbg_s_q; // Async sources are synchronised too
	logic cmp_prev_q;
	logic dbg_prev_q; // Debug level one cycle back, read by the bit 0 route
	logic [3:0] dma_prev_q;

	// Two-stage synchronisers, three stages for port C; stage one feeds stage two only
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			a_s1_q <= 8'h00;
			a_s2_q <= 8'h00;
			d_s1_q <= 8'h00;
			d_s2_q <= 8'h00;
			c_s1_q <= 4'h0;
			c_s2_q <= 4'h0;
			c_s3_q <= 4'h0;
			cmp_s_q <= 2'h0;
			dbg_s_q <= 2'h0;
		end else if (clk_en) begin
			a_s1_q <= port_a_pins;
			a_s2_q <= a_s1_q;
			d_s1_q <= port_d_pins;
			d_s2_q <= d_s1_q;
			c_s1_q <= port_c_pins;
			c_s2_q <= c_s1_q;
			c_s3_q <= c_s2_q;
			cmp_s_q <= {cmp_s_q[0], comparator_out};
			dbg_s_q <= {dbg_s_q[0], debug_unit_irq};
		end
	end

	// Selected A/D level per line
	logic [7:0] sel_lvl;
	assign sel_lvl = (a_s2_q & ~port_ad_irq_select_q) | (d_s2_q & port_ad_irq_select_q);

	// History of levels for edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sel_q <= 8'h00;
			cmp_prev_q <= 1'b0;
			dma_prev_q <= 4'h0;
		end else if (clk_en) begin
			sel_q <= sel_lvl;
			cmp_prev_q <= cmp_s_q[1];
			dma_prev_q <= dma_irq;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per-line request generation
	logic [7:0] ad_ev;
	logic [3:0] pc_ev;
	logic cmp_ev;
	// Comparator asks on both edges, unlike the one selected edge of the line 7 pin it shares
	assign cmp_ev = cmp_s_q[1] ^ cmp_prev_q;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_ad
			logic pin_ev;
			// edge polarity: rising when set, falling when clear
			assign pin_ev = port_irq_edge_select_q[gi]
				? (sel_lvl[gi] & ~sel_q[gi]) : (~sel_lvl[gi] & sel_q[gi]);
			if (gi == PISEL_CMP_BIT) begin : g_cmp
				assign ad_ev[gi] = aux_irq_source_select_q[PISEL_CMP_BIT]
					? cmp_ev : pin_ev;
			end else if (gi == PISEL_DBG_BIT) begin : g_dbg
				assign ad_ev[gi] = aux_irq_source_select_q[PISEL_DBG_BIT]
					? (dbg_s_q[1] & ~dbg_prev_q) : pin_ev;
			end else begin : g_pin
				assign ad_ev[gi] = pin_ev;
			end
		end
		for (gi = 0; gi < 4; gi++) begin : g_pc
			// DMA or pin; both pin edges
			assign pc_ev[gi] = portc_dma_irq_select_q[gi]
				? (c_s2_q[gi] ^ c_s3_q[gi]) : (dma_irq[gi] & ~dma_prev_q[gi]);
		end
	endgenerate

	// Debug interrupt history, rising edge gives one pulse
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dbg_prev_q <= 1'b0;
		end else if (clk_en) begin
			dbg_prev_q <= dbg_s_q[1];
		end
	end

	assign ev = {pc_ev, ad_ev};

	// Registered request pulses toward the controller
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ad_irq_req <= 8'h00;
			pc_irq_req <= 4'h0;
		end else if (clk_en) begin
			ad_irq_req <= ad_ev;
			pc_irq_req <= pc_ev;
		end else begin
			// Pulses must not stretch while frozen
			ad_irq_req <= 8'h00;
			pc_irq_req <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sticky status, mask and interrupt output
	// Status spans two bytes: low byte A/D lines, next byte port C
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			istat_q <= PISEL_EV_RST;
			imask_q <= PISEL_EV_RST;
		end else if (clk_en) begin
			// Set wins over write-one-to-clear in the same cycle
			if (wr_stat && reg_addr == PISEL_ADDR_ISTAT) begin
				istat_q <= (istat_q & ~{4'h0, reg_wdata}) | ev;
			end else if (wr_stat) begin
				istat_q <= (istat_q & ~{reg_wdata[3:0], 8'h00}) | ev;
			end else begin
				istat_q <= istat_q | ev;
			end
			if (wr_mask && reg_addr == PISEL_ADDR_IMASK) begin
				imask_q[7:0] <= reg_wdata;
			end else if (wr_mask) begin
				imask_q[11:8] <= reg_wdata[3:0];
			end
		end
	end

	// Level interrupt, registered
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(istat_q & imask_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			if (!reg_rd) begin
				reg_rdata <= 8'h00;
			end else begin
				case (reg_addr)
					PISEL_ADDR_AUX: reg_rdata <= aux_irq_source_select_q;
					PISEL_ADDR_PSEL: reg_rdata <= port_ad_irq_select_q;
					PISEL_ADDR_EDGE: reg_rdata <= port_irq_edge_select_q;
					PISEL_ADDR_PCSEL: reg_rdata <= portc_dma_irq_select_q;
					PISEL_ADDR_ISTAT: reg_rdata <= istat_q[7:0];
					PISEL_ADDR_IMASK: reg_rdata <= imask_q[7:0];
					PISEL_ADDR_ISTAT + 24'h000002: reg_rdata <= {4'h0, istat_q[11:8]};
					PISEL_ADDR_IMASK + 24'h000002: reg_rdata <= {4'h0, imask_q[11:8]};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions
	// Reserved aux bits always read zero
	a_aux_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(aux_irq_source_select_q & ~PISEL_AUX_WMASK) == 8'h00)
		else $error("aux reserved bits set");
	a_pc_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
		portc_dma_irq_select_q[7:4] == 4'h0)
		else $error("port C reserved bits set");
	a_req_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ad_irq_req[3] |=> !ad_irq_req[3])
		else $error("request longer than one cycle");
	a_cmp_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && aux_irq_source_select_q[7] && cmp_ev |=> ad_irq_req[7])
		else $error("comparator event not routed");
	a_dbg_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && aux_irq_source_select_q[0] && !(dbg_s_q[1] && !dbg_prev_q)
		|=> !ad_irq_req[0])
		else $error("pin event on debug-routed line");
	a_rise_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && port_irq_edge_select_q[2] && sel_lvl[2] && !sel_q[2]
		|=> ad_irq_req[2])
		else $error("rising edge missed");
	a_fall_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && port_irq_edge_select_q[4] && !sel_lvl[4] |=> !ad_irq_req[4])
		else $error("falling edge taken in rising mode");
	a_pc_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && portc_dma_irq_select_q[1] && (c_s2_q[1] != c_s3_q[1])
		|=> pc_irq_req[1])
		else $error("port C edge missed");
	a_bank_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
		port_ad_irq_select_q[5] |-> sel_lvl[5] == d_s2_q[5])
		else $error("wrong bank selected");
	a_dma_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !portc_dma_irq_select_q[0] && !dma_irq[0] |=> !pc_irq_req[0])
		else $error("pin event on DMA-routed line");
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && |(istat_q & imask_q) |=> irq)
		else $error("interrupt not raised");
	c_cmp_req: cover property (@(posedge ref_clk) disable iff (!rst_n)
		aux_irq_source_select_q[7] && ad_irq_req[7]);
	c_d_fall: cover property (@(posedge ref_clk) disable iff (!rst_n)
		port_ad_irq_select_q[1] && !port_irq_edge_select_q[1] && ad_irq_req[1]);
	c_pc_pin: cover property (@(posedge ref_clk) disable iff (!rst_n)
		portc_dma_irq_select_q[2] && pc_irq_req[2]);
	c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) irq);
endmodule : pisel_top

/* testbench/pisel_ictl_model.sv */
// Behavioural interrupt controller that counts the request pulses it receives
`timescale 1ns/1ps
module pisel_ictl_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] ad_irq_req,
	input wire logic [3:0] pc_irq_req,
	output logic [15:0] req_cnt_q
);
	////////////////////////////////////////
	// one count per pulse
	// Counting bits, not cycles, so a pulse held too long or doubled shows up
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_cnt_q <= 16'h0000;
		end else begin
			req_cnt_q <= req_cnt_q + 16'($countones({pc_irq_req, ad_irq_req}));
		end
	end
endmodule : pisel_ictl_model

/* testbench/tb_port_irq_source_select.sv */
// Self-checking bench for the port interrupt source selection block
`timescale 1ns/1ps
module tb_port_irq_source_select
	import pisel_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1; // Dropped once to prove a frozen write is ignored
	logic [23:0] reg_addr = 24'h000000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] port_a_pins = 8'h00;
	logic [7:0] port_d_pins = 8'h00;
	logic [3:0] port_c_pins = 4'h0;
	logic comparator_out = 1'b0;
	logic debug_unit_irq = 1'b0;
	logic [3:0] dma_irq = 4'h0;
	logic [7:0] ad_irq_req;
	logic [3:0] pc_irq_req;
	logic irq;
	logic [15:0] req_cnt;
	logic [11:0] evq[$]; // Expected request vectors
	logic [7:0] rdq[$]; // Expected read data
	logic arm = 1'b0; // Low while config changes may cause stray events
	logic rd_pend = 1'b0;
	logic [7:0] psel;
	logic [7:0] edg;
	logic [15:0] base;
	int errors = 0;
	int comparisons = 0;
	int seed = 30;
	pisel_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_a_pins(port_a_pins), .port_d_pins(port_d_pins), .port_c_pins(port_c_pins),
		.comparator_out(comparator_out), .debug_unit_irq(debug_unit_irq), .dma_irq(dma_irq),
		.ad_irq_req(ad_irq_req), .pc_irq_req(pc_irq_req), .irq(irq));
	pisel_ictl_model ictl_u (.ref_clk(ref_clk), .rst_n(rst_n), .ad_irq_req(ad_irq_req),
		.pc_irq_req(pc_irq_req), .req_cnt_q(req_cnt));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s exp=%h seen=%h", n, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// One-cycle write, then an idle cycle so strobes never collide
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [23:0] a, input logic [7:0] e);
		rdq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : rd
	// Config write with checking paused until stray events drain
	task automatic cfg(input logic [23:0] a, input logic [7:0] d);
		arm = 1'b0;
		wr(a, d);
		repeat (8) @(posedge ref_clk);
		arm = 1'b1;
	endtask : cfg
	// Note the expected pulse, wait bounded for it, then watch for extras
	task automatic step(input logic [11:0] e);
		if (e !== 12'h000) begin
			evq.push_back(e);
		end
		for (int i = 0; i < 12 && evq.size() != 0; i++) begin
			@(posedge ref_clk);
		end
		if (evq.size() != 0) begin
			chk("req_wait", 16'h0001, 16'h0000);
			end_sim();
		end else begin
			// Long enough for a stray port C pulse, which takes no more cycles than an A/D one
			repeat (6) @(posedge ref_clk);
		end
	endtask : step
	////////////////////////////////////////
	// Watcher: read data one cycle after strobe, pulses against oldest note
	always @(negedge ref_clk) begin
		if (rd_pend) begin
			chk("reg_rdata", 16'(reg_rdata), 16'(rdq.pop_front()));
		end
		rd_pend = reg_rd;
		if (arm && {pc_irq_req, ad_irq_req} !== 12'h000) begin
			chk("irq_req", 16'({pc_irq_req, ad_irq_req}),
				(evq.size() != 0) ? 16'(evq.pop_front()) : 16'hFFFF);
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Reset values and an unmapped address
		rd(PISEL_ADDR_AUX, 8'h00);
		rd(PISEL_ADDR_PSEL, 8'h00);
		rd(PISEL_ADDR_EDGE, 8'h00);
		rd(PISEL_ADDR_PCSEL, 8'h00);
		rd(24'hFFE110, 8'h00);
		// Write while frozen must not land
		clk_en <= 1'b0;
		wr(PISEL_ADDR_PSEL, 8'h5A);
		clk_en <= 1'b1;
		rd(PISEL_ADDR_PSEL, 8'h00);
		psel = 8'($random(seed));
		edg = 8'($random(seed));
		cfg(PISEL_ADDR_PSEL, psel);
		cfg(PISEL_ADDR_EDGE, edg);
		cfg(PISEL_ADDR_IMASK, 8'h00);
		cfg(PISEL_ADDR_ISTAT, 8'hFF);
		rd(PISEL_ADDR_PSEL, psel);
		rd(PISEL_ADDR_EDGE, edg);
		base = req_cnt;
		for (int x = 0; x < 8; x++) begin
			for (int v = 1; v >= 0; v--) begin
				port_a_pins[x] <= psel[x] ? v[0] : port_a_pins[x];
				port_d_pins[x] <= psel[x] ? port_d_pins[x] : v[0];
				step(12'h000);
				port_a_pins[x] <= v[0];
				port_d_pins[x] <= v[0];
				step((v[0] == edg[x]) ? 12'(1 << x) : 12'h000);
			end
		end
		chk("req_cnt", req_cnt - base, 16'h0008);
		chk("irq_masked", 16'(irq), 16'h0000);
		rd(PISEL_ADDR_ISTAT, 8'hFF);
		// Unmask one line, then clear it by writing one
		wr(PISEL_ADDR_IMASK, 8'h04);
		repeat (2) @(posedge ref_clk);
		chk("irq_set", 16'(irq), 16'h0001);
		wr(PISEL_ADDR_ISTAT, 8'h04);
		repeat (2) @(posedge ref_clk);
		chk("irq_clr", 16'(irq), 16'h0000);
		rd(PISEL_ADDR_ISTAT, 8'hFB);
		// routes; software keeps aux reserved bits zero
		cfg(PISEL_ADDR_AUX, 8'h81);
		rd(PISEL_ADDR_AUX, 8'h81);
		comparator_out <= 1'b1;
		step(12'h080);
		comparator_out <= 1'b0;
		step(12'h080);
		debug_unit_irq <= 1'b1;
		step(12'h001);
		debug_unit_irq <= 1'b0;
		step(12'h000);
		port_a_pins <= 8'h81;
		port_d_pins <= 8'h81;
		step(12'h000);
		port_a_pins <= 8'h00;
		port_d_pins <= 8'h00;
		step(12'h000);
		// pins on both edges, DMA on rising
		for (int s = 1; s >= 0; s--) begin
			cfg(PISEL_ADDR_PCSEL, s[0] ? 8'h0F : 8'h00);
			rd(PISEL_ADDR_PCSEL, s[0] ? 8'h0F : 8'h00);
			for (int x = 0; x < 4; x++) begin
				for (int v = 1; v >= 0; v--) begin
					dma_irq[x] <= v[0];
					step((!s[0] && v[0]) ? 12'(12'h100 << x) : 12'h000);
					port_c_pins[x] <= v[0];
					step(s[0] ? 12'(12'h100 << x) : 12'h000);
				end
			end
		end
		rd(24'hFFE132, 8'h0F);
		chk("queue_left", 16'(evq.size()), 16'h0000);
		end_sim();
	end
endmodule : tb_port_irq_source_select
